// file: rtl/crf_pkg.sv
// crf_pkg: constants, field positions and carrier types of the cpu register file
// assumes one core clock domain; all register indices double as wishbone word indices
package crf_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_DATA_ZERO  = 4'h0;
  localparam logic [3:0] IDX_DATA_ONE   = 4'h1;
  localparam logic [3:0] IDX_DATA_TWO   = 4'h2;
  localparam logic [3:0] IDX_DATA_THREE = 4'h3;
  localparam logic [3:0] IDX_ADDR_FIRST = 4'h4;
  localparam logic [3:0] IDX_ADDR_SECND = 4'h5;
  localparam logic [3:0] IDX_FRAME_BASE = 4'h6;
  localparam logic [3:0] IDX_INSTR_PTR  = 4'h7;
  localparam logic [3:0] IDX_VECT_BASE  = 4'h8;
  localparam logic [3:0] IDX_USER_SP    = 4'h9;
  localparam logic [3:0] IDX_INTR_SP    = 4'hA;
  localparam logic [3:0] IDX_STATIC_BS  = 4'hB;
  localparam logic [3:0] IDX_FLAGS      = 4'hC;
  localparam logic [3:0] IDX_ACTIVE_SP  = 4'hD;
  localparam logic [3:0] IDX_LAST       = 4'hD;
  localparam int         BANKED_COUNT   = 7;

  // ----------------------------------------------------------------
  // flag register fields
  // ----------------------------------------------------------------
  localparam int FLG_CARRY  = 0;
  localparam int FLG_DEBUG  = 1;
  localparam int FLG_ZERO   = 2;
  localparam int FLG_SIGN   = 3;
  localparam int FLG_BANK   = 4;
  localparam int FLG_OVFL   = 5;
  localparam int FLG_INTEN  = 6;
  localparam int FLG_USERSP = 7;
  localparam int FLG_IPL_LO = 12;
  localparam int FLG_IPL_HI = 14;
  localparam logic [15:0] FLG_IMPL_MASK = 16'h70FF;
  localparam logic [5:0]  SW_INT_USP_LIMIT = 6'h20;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [19:0] RST_ADDR  = 20'h00000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SZ_BYTE_LO, SZ_BYTE_HI, SZ_WORD, SZ_LONG} crf_size_type;

  typedef struct packed {
    logic         we;
    logic [3:0]   idx;
    crf_size_type size;
    logic [31:0]  wdata;
  } crf_core_req_type;

  typedef struct packed {
    logic valid;
    logic carry;
    logic zero;
    logic sign;
    logic ovfl;
  } crf_alu_flags_type;

  typedef struct packed {
    logic [BANKED_COUNT-1:0][15:0] bankZero;
    logic [BANKED_COUNT-1:0][15:0] bankOne;
    logic [19:0] instrPtr;
    logic [19:0] vectBase;
    logic [15:0] userSp;
    logic [15:0] intrSp;
    logic [15:0] staticBase;
    logic [15:0] flags;
    logic [15:0] activeSp;
    logic        wbAck;
    logic [31:0] wbDat;
    logic [31:0] coreRdata;
    logic        stepIrq;
    logic        intAccept;
  } crf_state_type;

endpackage : crf_pkg

// file: rtl/crf_regfile.sv
// crf_regfile: banked cpu register file with flags, core port and wishbone slave
// assumes core and bus share sys_clk; all inputs synchronous; ce low freezes everything except reset, which nrst applies regardless of ce
`timescale 1ns/1ps
module crf_regfile (
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  input  wire logic                       ce,
  input  wire logic                       wbCycI,
  input  wire logic                       wbStbI,
  input  wire logic                       wbWeI,
  input  wire logic [7:0]                 wbAdrI,
  input  wire logic [3:0]                 wbSelI,
  input  wire logic [31:0]                wbDatI,
  output      logic                       wbAckO,
  output      logic [31:0]                wbDatO,
  input  wire crf_pkg::crf_core_req_type  coreReq,
  output      logic [31:0]                coreRdata,
  input  wire crf_pkg::crf_alu_flags_type aluFlags,
  input  wire logic                       instrDone,
  input  wire logic                       stepAck,
  input  wire logic                       intReqValid,
  input  wire logic [2:0]                 intPrio,
  input  wire logic                       swIntValid,
  input  wire logic [5:0]                 swIntNum,
  output      logic                       stepIrq,
  output      logic                       intAccept,
  output      logic [15:0]                flagsOut,
  output      logic [15:0]                activeSp
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  crf_pkg::crf_state_type r_reg;
  crf_pkg::crf_state_type r_next;

  logic       wbReq;
  logic       wbWr;
  logic [3:0] wbIdx;
  logic       wbHit;
  logic       intOk;

  // ----------------------------------------------------------------
  // register access helpers
  // ----------------------------------------------------------------
  function automatic logic [19:0] getWord(input crf_pkg::crf_state_type s,
                                          input logic [3:0]             idx);
    logic [19:0] v;
    v = 20'h00000;
    if (idx < 4'(crf_pkg::BANKED_COUNT)) begin
      v = s.flags[crf_pkg::FLG_BANK] ? {4'h0, s.bankOne[idx[2:0]]}
                                     : {4'h0, s.bankZero[idx[2:0]]};
    end else begin
      case (idx)
        crf_pkg::IDX_INSTR_PTR: v = s.instrPtr;
        crf_pkg::IDX_VECT_BASE: v = s.vectBase;
        crf_pkg::IDX_USER_SP:   v = {4'h0, s.userSp};
        crf_pkg::IDX_INTR_SP:   v = {4'h0, s.intrSp};
        crf_pkg::IDX_STATIC_BS: v = {4'h0, s.staticBase};
        crf_pkg::IDX_FLAGS:     v = {4'h0, s.flags & crf_pkg::FLG_IMPL_MASK};
        crf_pkg::IDX_ACTIVE_SP: v = s.flags[crf_pkg::FLG_USERSP] ? {4'h0, s.userSp}
                                                                  : {4'h0, s.intrSp};
        default:                v = 20'h00000;
      endcase
    end
    return v;
  endfunction : getWord

  // steers by the flags of the edge (f), so a same-cycle flag write cannot redirect a write
  function automatic crf_pkg::crf_state_type putWord(input crf_pkg::crf_state_type s,
                                                     input logic [15:0]            f,
                                                     input logic [3:0]             idx,
                                                     input logic [19:0]            d);
    crf_pkg::crf_state_type t;
    t = s;
    if (idx < 4'(crf_pkg::BANKED_COUNT)) begin
      if (f[crf_pkg::FLG_BANK]) begin
        t.bankOne[idx[2:0]] = d[15:0];
      end else begin
        t.bankZero[idx[2:0]] = d[15:0];
      end
    end else begin
      case (idx)
        crf_pkg::IDX_INSTR_PTR: t.instrPtr   = d;
        crf_pkg::IDX_VECT_BASE: t.vectBase   = d;
        crf_pkg::IDX_USER_SP:   t.userSp     = d[15:0];
        crf_pkg::IDX_INTR_SP:   t.intrSp     = d[15:0];
        crf_pkg::IDX_STATIC_BS: t.staticBase = d[15:0];
        crf_pkg::IDX_FLAGS:     t.flags      = d[15:0] & crf_pkg::FLG_IMPL_MASK;
        crf_pkg::IDX_ACTIVE_SP: begin
          if (f[crf_pkg::FLG_USERSP]) begin
            t.userSp = d[15:0];
          end else begin
            t.intrSp = d[15:0];
          end
        end
        default: t = s;
      endcase
    end
    return t;
  endfunction : putWord

  // long partner: data zero/one pair with two/three, address first with second
  function automatic logic [3:0] pairIdx(input logic [3:0] idx);
    logic [3:0] p;
    p = 4'hF;
    case (idx)
      crf_pkg::IDX_DATA_ZERO:  p = crf_pkg::IDX_DATA_TWO;
      crf_pkg::IDX_DATA_ONE:   p = crf_pkg::IDX_DATA_THREE;
      crf_pkg::IDX_ADDR_FIRST: p = crf_pkg::IDX_ADDR_SECND;
      default:                 p = 4'hF;
    endcase
    return p;
  endfunction : pairIdx

  function automatic logic byteOk(input logic [3:0] idx);
    return (idx == crf_pkg::IDX_DATA_ZERO) || (idx == crf_pkg::IDX_DATA_ONE);
  endfunction : byteOk

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign wbReq = wbCycI && wbStbI && !r_reg.wbAck;
  assign wbIdx = wbAdrI[5:2];
  assign wbHit = (wbAdrI[7:6] == 2'b00) && (wbIdx <= crf_pkg::IDX_LAST);
  assign wbWr  = wbReq && wbWeI && wbHit;
  assign intOk = intReqValid && r_reg.flags[crf_pkg::FLG_INTEN] && !r_reg.intAccept
                 && (intPrio > r_reg.flags[crf_pkg::FLG_IPL_HI:crf_pkg::FLG_IPL_LO]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] laneMask;
    logic [19:0] oldWord;
    logic [19:0] mergedWord;
    logic [3:0]  hiIdx;
    logic [15:0] curWord;
    logic [19:0] curFull;
    logic [19:0] hiFull;
    r_next     = r_reg;
    laneMask   = {{8{wbSelI[3]}}, {8{wbSelI[2]}}, {8{wbSelI[1]}}, {8{wbSelI[0]}}};
    oldWord    = getWord(r_reg, wbIdx);
    mergedWord = (oldWord & ~laneMask[19:0]) | (wbDatI[19:0] & laneMask[19:0]);
    hiIdx      = pairIdx(coreReq.idx);
    curFull    = getWord(r_reg, coreReq.idx);
    hiFull     = getWord(r_reg, hiIdx);
    curWord    = curFull[15:0];

    // one-cycle ack; unmapped reads answer zero, unmapped writes are dropped
    r_next.wbAck = wbReq;
    r_next.wbDat = (wbReq && wbHit) ? {12'h000, oldWord} : 32'h00000000;
    if (wbWr) begin
      r_next = putWord(r_next, r_reg.flags, wbIdx, mergedWord);
    end

    // core port; bus write lands first so a same-cycle core write wins
    case (coreReq.size)
      crf_pkg::SZ_BYTE_LO: r_next.coreRdata = {24'h000000, curWord[7:0]};
      crf_pkg::SZ_BYTE_HI: r_next.coreRdata = {24'h000000, curWord[15:8]};
      crf_pkg::SZ_WORD:    r_next.coreRdata = {12'h000, curFull};
      crf_pkg::SZ_LONG:    r_next.coreRdata = {hiFull[15:0], curWord};
      default:             r_next.coreRdata = 32'h00000000;
    endcase
    if (coreReq.we) begin
      case (coreReq.size)
        crf_pkg::SZ_BYTE_LO: begin
          if (byteOk(coreReq.idx)) begin
            r_next = putWord(r_next, r_reg.flags, coreReq.idx,
                             {4'h0, curWord[15:8], coreReq.wdata[7:0]});
          end
        end
        crf_pkg::SZ_BYTE_HI: begin
          if (byteOk(coreReq.idx)) begin
            r_next = putWord(r_next, r_reg.flags, coreReq.idx,
                             {4'h0, coreReq.wdata[7:0], curWord[7:0]});
          end
        end
        crf_pkg::SZ_WORD: begin
          r_next = putWord(r_next, r_reg.flags, coreReq.idx, coreReq.wdata[19:0]);
        end
        crf_pkg::SZ_LONG: begin
          if (hiIdx != 4'hF) begin
            r_next = putWord(r_next, r_reg.flags, coreReq.idx, {4'h0, coreReq.wdata[15:0]});
            r_next = putWord(r_next, r_reg.flags, hiIdx, {4'h0, coreReq.wdata[31:16]});
          end
        end
        default: r_next = r_next;
      endcase
    end

    // hardware flag events come last so they win over software writes
    if (aluFlags.valid) begin
      r_next.flags[crf_pkg::FLG_CARRY] = aluFlags.carry;
      r_next.flags[crf_pkg::FLG_ZERO]  = aluFlags.zero;
      r_next.flags[crf_pkg::FLG_SIGN]  = aluFlags.sign;
      r_next.flags[crf_pkg::FLG_OVFL]  = aluFlags.ovfl;
    end
    r_next.stepIrq = instrDone && r_reg.flags[crf_pkg::FLG_DEBUG];
    if (stepAck) begin
      r_next.flags[crf_pkg::FLG_DEBUG] = 1'b0;
    end
    r_next.intAccept = intOk;
    if (intOk) begin
      r_next.flags[crf_pkg::FLG_INTEN]  = 1'b0;
      r_next.flags[crf_pkg::FLG_USERSP] = 1'b0;
    end
    if (swIntValid && (swIntNum < crf_pkg::SW_INT_USP_LIMIT)) begin
      r_next.flags[crf_pkg::FLG_USERSP] = 1'b0;
    end
    r_next.flags    = r_next.flags & crf_pkg::FLG_IMPL_MASK;
    r_next.activeSp = r_next.flags[crf_pkg::FLG_USERSP] ? r_next.userSp
                                                         : r_next.intrSp;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r_reg            <= '0;
      r_reg.instrPtr   <= crf_pkg::RST_ADDR;
      r_reg.vectBase   <= crf_pkg::RST_ADDR;
      r_reg.userSp     <= crf_pkg::RST_WORD;
      r_reg.intrSp     <= crf_pkg::RST_WORD;
      r_reg.staticBase <= crf_pkg::RST_WORD;
      r_reg.flags      <= crf_pkg::RST_FLAGS;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign wbAckO    = r_reg.wbAck;
  assign wbDatO    = r_reg.wbDat;
  assign coreRdata = r_reg.coreRdata;
  assign stepIrq   = r_reg.stepIrq;
  assign intAccept = r_reg.intAccept;
  assign flagsOut  = r_reg.flags;
  assign activeSp  = r_reg.activeSp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_wbTaken;
    ce && wbCycI && wbStbI && !wbAckO;
  endsequence
  sequence s_wbAnswered;
    wbAckO ##1 (!$past(ce) || !wbAckO);
  endsequence

  property p_wbAck;
    s_wbTaken |=> s_wbAnswered;
  endproperty
  a_wbAck: assert property (p_wbAck) else $error("bus ack not a single cycle pulse");

  property p_resvZero;
    (flagsOut & ~crf_pkg::FLG_IMPL_MASK) == 16'h0000;
  endproperty
  a_resvZero: assert property (p_resvZero) else $error("reserved flag bit set");

  property p_stepIrq;
    ce && instrDone && flagsOut[crf_pkg::FLG_DEBUG] |=> stepIrq;
  endproperty
  a_stepIrq: assert property (p_stepIrq) else $error("single step not raised");

  property p_stepClr;
    ce && stepAck |=> !flagsOut[crf_pkg::FLG_DEBUG];
  endproperty
  a_stepClr: assert property (p_stepClr) else $error("debug flag not cleared");

  property p_intClr;
    intAccept |-> !flagsOut[crf_pkg::FLG_USERSP] && !flagsOut[crf_pkg::FLG_INTEN]
                  && (activeSp == r_reg.intrSp);
  endproperty
  a_intClr: assert property (p_intClr) else $error("accept left user stack selected");

  property p_intPrio;
    ce && intReqValid && flagsOut[crf_pkg::FLG_INTEN] && !intAccept
       && (intPrio > flagsOut[crf_pkg::FLG_IPL_HI:crf_pkg::FLG_IPL_LO]) |=> intAccept;
  endproperty
  a_intPrio: assert property (p_intPrio) else $error("eligible interrupt not accepted");

  property p_intLow;
    ce && (intPrio <= flagsOut[crf_pkg::FLG_IPL_HI:crf_pkg::FLG_IPL_LO]) |=> !intAccept;
  endproperty
  a_intLow: assert property (p_intLow) else $error("low priority interrupt accepted");

  property p_aluFlags;
    ce && aluFlags.valid |=> flagsOut[crf_pkg::FLG_ZERO] == $past(aluFlags.zero)
                          && flagsOut[crf_pkg::FLG_SIGN] == $past(aluFlags.sign);
  endproperty
  a_aluFlags: assert property (p_aluFlags) else $error("zero or sign flag wrong");

  property p_carryOvfl;
    ce && aluFlags.valid |=> flagsOut[crf_pkg::FLG_CARRY] == $past(aluFlags.carry)
                          && flagsOut[crf_pkg::FLG_OVFL] == $past(aluFlags.ovfl);
  endproperty
  a_carryOvfl: assert property (p_carryOvfl) else $error("carry or overflow wrong");

  property p_bankSteer;
    ce && coreReq.we && coreReq.size == crf_pkg::SZ_WORD
       && coreReq.idx == crf_pkg::IDX_DATA_ZERO && flagsOut[crf_pkg::FLG_BANK]
       |=> r_reg.bankOne[0] == $past(coreReq.wdata[15:0])
           && r_reg.bankZero[0] == $past(r_reg.bankZero[0]);
  endproperty
  a_bankSteer: assert property (p_bankSteer) else $error("write went to wrong bank");

  property p_swInt;
    ce && swIntValid && (swIntNum < crf_pkg::SW_INT_USP_LIMIT)
       |=> !flagsOut[crf_pkg::FLG_USERSP];
  endproperty
  a_swInt: assert property (p_swInt) else $error("low software interrupt kept user stack");

  property p_intOnce;
    ce && intAccept |=> !intAccept;
  endproperty
  a_intOnce: assert property (p_intOnce) else $error("accept held two cycles");

  // frozen core: flags, active sp, core read data and bus ack may not move while ce is low
  property p_freeze;
    !ce |=> $stable(flagsOut) && $stable(activeSp) && $stable(coreRdata) && $stable(wbAckO);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with ce low");

  property p_activeSp;
    activeSp == (flagsOut[crf_pkg::FLG_USERSP] ? r_reg.userSp : r_reg.intrSp);
  endproperty
  a_activeSp: assert property (p_activeSp) else $error("active stack pointer mismatch");

endmodule : crf_regfile

// file: verif/crf_regfile_tb.sv
// crf_regfile_tb: self-checking bench for the banked register file, flags and core port
// assumes the crf_pkg package is compiled first; bench is the only wishbone master
`timescale 1ns/1ps
module crf_regfile_tb;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic                        sys_clk = 1'b0;
  logic                        nrst, ce, wbCycI, wbStbI, wbWeI, wbAckO;
  logic [7:0]                  wbAdrI;
  logic [3:0]                  wbSelI;
  logic [31:0]                 wbDatI, wbDatO, coreRdata;
  crf_pkg::crf_core_req_type   coreReq;
  crf_pkg::crf_alu_flags_type  aluFlags;
  logic                        instrDone, stepAck, intReqValid, swIntValid, stepIrq, intAccept;
  logic [2:0]                  intPrio;
  logic [5:0]                  swIntNum;
  logic [15:0]                 flagsOut, activeSp;
  int                          mismatches, nChecks;

  always #2 sys_clk = ~sys_clk;

  crf_regfile dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .wbCycI(wbCycI), .wbStbI(wbStbI),
    .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbAckO(wbAckO),
    .wbDatO(wbDatO), .coreReq(coreReq), .coreRdata(coreRdata), .aluFlags(aluFlags),
    .instrDone(instrDone), .stepAck(stepAck), .intReqValid(intReqValid), .intPrio(intPrio),
    .swIntValid(swIntValid), .swIntNum(swIntNum), .stepIrq(stepIrq), .intAccept(intAccept),
    .flagsOut(flagsOut), .activeSp(activeSp));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : check

  task give_verdict;
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // access tasks; each is entered and left just after a rising edge
  // ----------------------------------------------------------------
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel, output logic [31:0] rd);
    int n;
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI  <= we;
    wbAdrI <= adr;
    wbSelI <= sel;
    wbDatI <= dat;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAckO !== 1'b1 && n < 20);
    if (wbAckO !== 1'b1) begin
      $display("[ERR] wbAckO expected 1 seen %b", wbAckO);
      mismatches++;
      give_verdict();
    end
    rd = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    wbWeI  <= 1'b0;
    @(posedge sys_clk);
  endtask : wb_cycle

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] v;
    wb_cycle(1'b1, {2'b00, idx, 2'b00}, d, 4'hF, v);
  endtask : wr

  task automatic rd_chk(input string what, input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    wb_cycle(1'b0, {2'b00, idx, 2'b00}, 32'h0, 4'hF, v);
    check(what, exp, v);
  endtask : rd_chk

  task automatic core_op(input logic we, input logic [3:0] idx,
                         input crf_pkg::crf_size_type sz, input logic [31:0] wd);
    coreReq <= '{we: we, idx: idx, size: sz, wdata: wd};
    @(posedge sys_clk);
    coreReq.we <= 1'b0;
    @(posedge sys_clk);
  endtask : core_op

  // pulses last one cycle; outputs are sampled one edge after they land
  task fire;
    @(posedge sys_clk);
    aluFlags    <= '0;
    instrDone   <= 1'b0;
    stepAck     <= 1'b0;
    intReqValid <= 1'b0;
    swIntValid  <= 1'b0;
    @(posedge sys_clk);
  endtask : fire

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] p;
    int         i;
    logic [31:0] v;
    nrst = 1'b0; ce = 1'b1; wbCycI = 1'b0; wbStbI = 1'b0; wbWeI = 1'b0;
    wbAdrI = 8'h00; wbSelI = 4'h0; wbDatI = 32'h0; coreReq = '0; aluFlags = '0;
    instrDone = 1'b0; stepAck = 1'b0; intReqValid = 1'b0; intPrio = 3'h0;
    swIntValid = 1'b0; swIntNum = 6'h00; mismatches = 0; nChecks = 0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < 14; i++) rd_chk("reset value", i[3:0], 32'h0);
    for (i = 0; i < 12; i++) begin
      wr(i[3:0], 32'hFFFFFFFF);
      rd_chk("register width", i[3:0], (i == 7 || i == 8) ? 32'h000FFFFF : 32'h0000FFFF);
    end
    wr(4'hC, 32'h0000FFFF);
    rd_chk("flags reserved", 4'hC, 32'h000070FF);
    check("flagsOut", 32'h000070FF, {16'h0, flagsOut});
    rd_chk("bank one fresh", 4'h0, 32'h0);
    wr(4'h0, 32'h2222);
    wr(4'h6, 32'h6666);
    wr(4'hC, 32'h0);
    rd_chk("bank zero kept", 4'h0, 32'hFFFF);
    rd_chk("bank zero frame", 4'h6, 32'hFFFF);
    wr(4'hC, 32'h0010);
    rd_chk("bank one data", 4'h0, 32'h2222);
    wr(4'hC, 32'h0);
    // stack selection follows bit 7
    wr(4'h9, 32'h1234);
    wr(4'hA, 32'h5678);
    check("interrupt sp active", 32'h5678, {16'h0, activeSp});
    wr(4'hC, 32'h0080);
    check("user sp active", 32'h1234, {16'h0, activeSp});
    rd_chk("active sp alias", 4'hD, 32'h1234);
    wr(4'hC, 32'h0);
    // byte and long access
    wr(4'h0, 32'h1111);
    core_op(1'b1, 4'h0, crf_pkg::SZ_BYTE_HI, 32'hAB);
    rd_chk("upper byte write", 4'h0, 32'hAB11);
    core_op(1'b1, 4'h1, crf_pkg::SZ_BYTE_LO, 32'hCD);
    rd_chk("lower byte write", 4'h1, 32'hFFCD);
    core_op(1'b0, 4'h0, crf_pkg::SZ_BYTE_HI, 32'h0);
    check("upper byte read", 32'hAB, coreRdata);
    core_op(1'b1, 4'h0, crf_pkg::SZ_LONG, 32'h22223333);
    rd_chk("long low half", 4'h0, 32'h3333);
    rd_chk("long high half", 4'h2, 32'h2222);
    wr(4'h3, 32'hBEEF);
    wr(4'h1, 32'hCAFE);
    core_op(1'b0, 4'h1, crf_pkg::SZ_LONG, 32'h0);
    check("long read", 32'hBEEFCAFE, coreRdata);
    core_op(1'b1, 4'h4, crf_pkg::SZ_LONG, 32'h44445555);
    rd_chk("address pair low", 4'h4, 32'h5555);
    rd_chk("address pair high", 4'h5, 32'h4444);
    core_op(1'b1, 4'h2, crf_pkg::SZ_BYTE_LO, 32'h77);
    rd_chk("byte on wide reg", 4'h2, 32'h2222);
    // core word write into bank one, then a write while frozen
    wr(4'hC, 32'h0010);
    core_op(1'b1, 4'h0, crf_pkg::SZ_WORD, 32'h5A5A);
    rd_chk("bank one word", 4'h0, 32'h5A5A);
    ce <= 1'b0;
    core_op(1'b1, 4'h0, crf_pkg::SZ_WORD, 32'h1234);
    ce <= 1'b1;
    rd_chk("frozen write", 4'h0, 32'h5A5A);
    wr(4'hC, 32'h0);
    wb_cycle(1'b1, 8'h0C, 32'h12, 4'h1, v);
    rd_chk("lane merge", 4'h3, 32'hBE12);
    wb_cycle(1'b1, 8'h40, 32'h9999, 4'hF, v);
    rd_chk("unmapped no alias", 4'h0, 32'h3333);
    wb_cycle(1'b0, 8'h38, 32'h0, 4'hF, v);
    check("unmapped read", 32'h0, v);
    // arithmetic flags, both polarities of each
    for (i = 0; i < 2; i++) begin
      p = (i == 0) ? 4'h5 : 4'hA;
      aluFlags <= '{valid: 1'b1, carry: p[0], zero: p[1], sign: p[2], ovfl: p[3]};
      fire();
      check("alu flags", {26'h0, p[3], 1'b0, p[2], p[1], 1'b0, p[0]},
            {16'h0, flagsOut & 16'h002D});
    end
    // single step
    wr(4'hC, 32'h0002);
    instrDone <= 1'b1;
    fire();
    check("step request", 32'h1, {31'h0, stepIrq});
    stepAck <= 1'b1;
    fire();
    check("debug cleared", 32'h0, {31'h0, flagsOut[1]});
    // maskable interrupt against priority level 3
    wr(4'hC, 32'h30C0);
    intPrio     <= 3'h3;
    intReqValid <= 1'b1;
    fire();
    check("equal prio refused", 32'h0, {31'h0, intAccept});
    check("flags kept", 32'h30C0, {16'h0, flagsOut});
    intPrio     <= 3'h4;
    intReqValid <= 1'b1;
    fire();
    check("higher prio taken", 32'h1, {31'h0, intAccept});
    check("accept clears I and U", 32'h3000, {16'h0, flagsOut});
    check("accept selects isp", 32'h5678, {16'h0, activeSp});
    // software interrupt numbers at the boundary
    for (i = 31; i < 33; i++) begin
      wr(4'hC, 32'h0080);
      swIntNum   <= i[5:0];
      swIntValid <= 1'b1;
      fire();
      check("sw int stack flag", (i < 32) ? 32'h0 : 32'h80, {16'h0, flagsOut});
    end
    give_verdict();
  end

endmodule : crf_regfile_tb
